// [design/aal1_regs.vh]
`ifndef AAL1_REGS_VH
`define AAL1_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define CNT_OFS 8'h08
`define SIG_BASE 8'h40
`define SIG_LAST 8'hb4
`define SIG_NUM 30
// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define CTRL_RST 8'h00
`define C_EN 0
`define C_FAST 1
`define C_ADAPT 2
`define C_DS1 3
`define C_ALARM 4
`define C_SIGSUB 5
`define C_GRP 7:6
// ----------------------------------------
// Cell, pointer and stamp figures
// ----------------------------------------
`define PAYLOAD_OCT 9'h02f
`define PTR_SPAN 7'h5d
`define PTR_DUMMY 7'h7f
`define LAST_SC 3'h7
`define RTS_N 12'hbc0
`define NET_X 6
`define E1_LAST 5'h0f
`define DS1_LAST 5'h18
// ----------------------------------------
// Timing: line rate over system clock
// ----------------------------------------
`define DATA_KHZ 64'd2048
`define CLK_KHZ 64'd250000
`define DCO_NOM64 ((`DATA_KHZ << 32) / `CLK_KHZ)
`define FILL_MID 9'h080
`endif

// [design/seq_check.v]
`timescale 1ns/1ps
`default_nettype none
`include "aal1_regs.vh"
module seq_check (
  input wire hclk,
  input wire hresetn,
  input wire enable,
  input wire fast,
  input wire cell_valid,
  input wire [2:0] cell_sn,
  output reg accept,
  output reg discard,
  output reg dummy_valid,
  output reg [2:0] dummy_num,
  output reg [2:0] state
);
  localparam ST_START = 3'h0;
  localparam ST_HUNT = 3'h1;
  localparam ST_SYNC = 3'h2;
  localparam ST_INVALID = 3'h3;
  localparam ST_OFF = 3'h4;
  reg [2:0] held_reg;
  reg [2:0] good_reg;
  reg [2:0] state_next;
  reg [2:0] held_next;
  reg [2:0] good_next;
  reg acc_next;
  reg disc_next;
  reg dum_next;
  reg [2:0] num_next;
  // ----------------------------------------
  // Decision on each arriving cell
  // ----------------------------------------
  always @* begin
    state_next = state;
    held_next = held_reg;
    good_next = good_reg;
    acc_next = 1'b0;
    disc_next = 1'b0;
    dum_next = 1'b0;
    num_next = 3'h0;
    if (!enable) begin
      state_next = ST_OFF;
    end else if (state == ST_OFF) begin
      state_next = ST_START;
    end else if (cell_valid) begin
      held_next = cell_sn;
      case (state)
        ST_START: begin
          state_next = ST_HUNT;
        end
        ST_HUNT: begin
          if (cell_sn == held_reg + 3'h1) begin
            acc_next = 1'b1;
            good_next = fast ? cell_sn : held_reg;
            state_next = ST_SYNC;
          end else begin
            disc_next = 1'b1;
          end
        end
        ST_SYNC: begin
          acc_next = 1'b1;
          if (fast) begin
            good_next = cell_sn;
            if (cell_sn != good_reg + 3'h1) begin
              good_next = good_reg;
              state_next = ST_INVALID;
            end
          end else begin
            good_next = held_reg;
            if (cell_sn != held_reg + 3'h1) begin
              state_next = ST_INVALID;
            end
          end
        end
        ST_INVALID: begin
          if (cell_sn == good_reg + 3'h1) begin
            disc_next = 1'b1;
            good_next = fast ? cell_sn : good_reg;
            state_next = ST_SYNC;
          end else if (cell_sn == held_reg + 3'h1) begin
            acc_next = 1'b1;
            dum_next = 1'b1;
            num_next = held_reg - good_reg - 3'h1;
            good_next = fast ? cell_sn : held_reg;
            state_next = ST_SYNC;
          end else begin
            disc_next = 1'b1;
            state_next = ST_HUNT;
          end
        end
        default: begin
          state_next = ST_START;
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_OFF;
      held_reg <= 3'h0;
      good_reg <= 3'h0;
      accept <= 1'b0;
      discard <= 1'b0;
      dummy_valid <= 1'b0;
      dummy_num <= 3'h0;
    end else begin
      state <= state_next;
      held_reg <= held_next;
      good_reg <= good_next;
      accept <= acc_next;
      discard <= disc_next;
      dummy_valid <= dum_next;
      dummy_num <= num_next;
    end
  end
endmodule
`default_nettype wire

// [design/rts_gen.v]
`timescale 1ns/1ps
`default_nettype none
`include "aal1_regs.vh"
module rts_gen (
  input wire hclk,
  input wire hresetn,
  input wire data_tick,
  input wire net_tick,
  output reg [3:0] rts_value
);
  reg [`NET_X-1:0] pre_reg;
  reg [11:0] data_cnt_reg;
  reg [3:0] measured_network_count;
  wire fnx = net_tick && (pre_reg == {`NET_X{1'b1}});
  wire [3:0] meas_now = measured_network_count + {3'h0, fnx};
  // ----------------------------------------
  // Residual of derived network count
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= {`NET_X{1'b0}};
      data_cnt_reg <= 12'h000;
      measured_network_count <= 4'h0;
      rts_value <= 4'h0;
    end else begin
      if (net_tick) begin
        pre_reg <= pre_reg + 1'b1;
      end
      measured_network_count <= meas_now;
      if (data_tick) begin
        if (data_cnt_reg == `RTS_N - 12'h001) begin
          data_cnt_reg <= 12'h000;
          rts_value <= meas_now;
        end else begin
          data_cnt_reg <= data_cnt_reg + 12'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [design/aal1_top.v]
// Overview of operation
// - Hold each received cell until its successor's sequence number is compared.
// - Robust mode: accept or discard applies to the held cell.
// - Sequence checker is a five-state machine; each cell in HUNT, SYNC or INVALID yields an action.
// - Counts wrap modulo eight; detect up to six lost, one misinserted.
// - Each lost cell becomes one dummy cell of 47 octets.
// - Robust mode deletes a misinserted cell before reassembly.
// - Fast mode acts on current cell; after misinsertion next good cell dropped.
// - Each cell carries 47 octets of user payload.
// - Pointer is binary octet offset to block start within 93-octet span.
// - Exactly one pointer per eight-cell cycle, counts 0 to 7.
// - Pointer at first block start opportunity, else 127 at last opportunity.
// - Four stamp bits spread one per odd cell over eight cells.
// - Count derived network clock, 19440x8 kHz over 64, across 3008 data cycles.
// - Send only four-bit deviation of the measured count.
// - Received minus local stamp steers an oscillator as a loop.
// - Adaptive mode adjusts transmit rate from receive buffer fill.
// - Each multiframe gives a payload part, optionally a signalling part.
// - E1 multiframe of sixteen frames; 0000 alignment in slot 16 frame 0.
// - E1 frames 1-15 carry channel n and n+15 signalling in slot 16.
// - Frame 0 spare bits set to 1; alarm bit 1 only in alarm.
// - DS1 frames 6,12,18,24 carry signalling in bit 8 of every slot.
// - DS1 groupings: four, two or one signalling channel.
`timescale 1ns/1ps
`default_nettype none
`include "aal1_regs.vh"
module aal1_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire rx_cell_valid,
  input wire [2:0] rx_cell_sn,
  input wire rx_cell_csi,
  output wire rx_accept,
  output wire rx_discard,
  output reg rx_dummy_octet,
  input wire tx_cell_req,
  input wire blk_start_valid,
  input wire [6:0] blk_start_off,
  output reg tx_cell_valid,
  output reg [2:0] tx_sc,
  output reg tx_csi,
  output reg ptr_valid,
  output reg [6:0] ptr_value,
  input wire data_tick,
  input wire net_tick,
  input wire [7:0] fill_level,
  output reg tx_clk_tick,
  input wire frame_tick,
  input wire [4:0] ds1_chan,
  output reg [7:0] ts16_byte,
  output reg robbed_frame,
  output reg robbed_bit,
  output reg signalling_multiframe_start,
  output reg sig_sub_valid
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function sig_hit;
    input [7:0] a;
    begin
      sig_hit = (a >= `SIG_BASE) && (a <= `SIG_LAST) && (a[1:0] == 2'h0);
    end
  endfunction

  function [4:0] sig_idx;
    input [7:0] a;
    reg [7:0] d;
    begin
      d = a - `SIG_BASE;
      sig_idx = d[6:2];
    end
  endfunction

  function sig_pick;
    input [3:0] nib;
    input [1:0] q;
    input [1:0] grp;
    begin
      case (grp)
        2'h0: sig_pick = nib[3 - q];
        2'h1: sig_pick = q[0] ? nib[2] : nib[3];
        default: sig_pick = nib[3];
      endcase
    end
  endfunction

  function is_robbed;
    input [4:0] f;
    begin
      is_robbed = (f == 5'h06) || (f == 5'h0c) || (f == 5'h12) || (f == 5'h18);
    end
  endfunction

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  reg [7:0] ctrl_reg;
  reg [3:0] sig_mem [0:`SIG_NUM-1];
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [15:0] dummy_cnt_reg;
  reg [15:0] disc_cnt_reg;
  reg [31:0] rd_mux;
  reg [3:0] rx_rts_reg;
  reg [3:0] tx_rts_reg;
  wire [3:0] tx_rts;
  wire [3:0] loc_rts;
  wire [2:0] seq_state;
  wire ahb_go = hsel && htrans[1] && hready;
  integer i;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == `CTRL_OFS) begin
      rd_mux = {24'h00_0000, ctrl_reg};
    end else if (haddr[7:0] == `STAT_OFS) begin
      rd_mux = {13'h0000, seq_state, 4'h0, loc_rts, rx_rts_reg, tx_rts_reg};
    end else if (haddr[7:0] == `CNT_OFS) begin
      rd_mux = {disc_cnt_reg, dummy_cnt_reg};
    end else if (sig_hit(haddr[7:0])) begin
      rd_mux = {28'h000_0000, sig_mem[sig_idx(haddr[7:0])]};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      ctrl_reg <= `CTRL_RST;
      for (i = 0; i < `SIG_NUM; i = i + 1) begin
        sig_mem[i] <= 4'h0;
      end
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= ahb_go && hwrite;
      if (ahb_go) begin
        wr_addr_reg <= haddr[7:0];
        hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr_pend_reg) begin
        if (wr_addr_reg == `CTRL_OFS) begin
          ctrl_reg <= hwdata[7:0];
        end
        for (i = 0; i < `SIG_NUM; i = i + 1) begin
          if (sig_hit(wr_addr_reg) && sig_idx(wr_addr_reg) == i) begin
            sig_mem[i] <= hwdata[3:0];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Receive sequence check and dummies
  // ----------------------------------------
  wire dummy_valid;
  wire [2:0] dummy_num;
  reg [8:0] dummy_left_reg;
  reg [2:0] rx_sh_reg;
  wire [8:0] dummy_add = {6'h00, dummy_num} * `PAYLOAD_OCT;

  seq_check u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(ctrl_reg[`C_EN]),
    .fast(ctrl_reg[`C_FAST]),
    .cell_valid(rx_cell_valid),
    .cell_sn(rx_cell_sn),
    .accept(rx_accept),
    .discard(rx_discard),
    .dummy_valid(dummy_valid),
    .dummy_num(dummy_num),
    .state(seq_state)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dummy_left_reg <= 9'h000;
      rx_dummy_octet <= 1'b0;
      dummy_cnt_reg <= 16'h0000;
      disc_cnt_reg <= 16'h0000;
      rx_sh_reg <= 3'h0;
      rx_rts_reg <= 4'h0;
    end else begin
      rx_dummy_octet <= (dummy_left_reg != 9'h000);
      dummy_left_reg <= dummy_left_reg - {8'h00, dummy_left_reg != 9'h000}
                        + (dummy_valid ? dummy_add : 9'h000);
      if (dummy_valid) begin
        dummy_cnt_reg <= dummy_cnt_reg + {13'h0000, dummy_num};
      end
      if (rx_discard) begin
        disc_cnt_reg <= disc_cnt_reg + 16'h0001;
      end
      if (rx_cell_valid && rx_cell_sn[0]) begin
        rx_sh_reg <= {rx_sh_reg[1:0], rx_cell_csi};
        if (rx_cell_sn == `LAST_SC) begin
          rx_rts_reg <= {rx_sh_reg, rx_cell_csi};
        end
      end
    end
  end

  // ----------------------------------------
  // Transmit pointer and stamp bits
  // ----------------------------------------
  reg [2:0] sc_reg;
  reg ptr_done_reg;
  wire blk_ok = blk_start_valid && (blk_start_off < `PTR_SPAN);
  wire use_ptr = !ptr_done_reg && (blk_ok || sc_reg == `LAST_SC);
  wire [3:0] rts_now = (sc_reg == 3'h0) ? tx_rts : tx_rts_reg;

  rts_gen u_tx_rts (
    .hclk(hclk),
    .hresetn(hresetn),
    .data_tick(data_tick),
    .net_tick(net_tick),
    .rts_value(tx_rts)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc_reg <= 3'h0;
      ptr_done_reg <= 1'b0;
      tx_cell_valid <= 1'b0;
      tx_sc <= 3'h0;
      tx_csi <= 1'b0;
      ptr_valid <= 1'b0;
      ptr_value <= 7'h00;
      tx_rts_reg <= 4'h0;
    end else begin
      tx_cell_valid <= tx_cell_req;
      if (tx_cell_req) begin
        tx_sc <= sc_reg;
        sc_reg <= sc_reg + 3'h1;
        tx_rts_reg <= rts_now;
        ptr_valid <= use_ptr;
        ptr_value <= blk_ok ? blk_start_off : `PTR_DUMMY;
        if (sc_reg[0]) begin
          tx_csi <= rts_now[3 - sc_reg[2:1]];
        end else begin
          tx_csi <= use_ptr;
        end
        ptr_done_reg <= (sc_reg != `LAST_SC) && (ptr_done_reg || use_ptr);
      end
    end
  end

  // ----------------------------------------
  // Clock recovery oscillator
  // ----------------------------------------
  reg [31:0] dco_acc_reg;
  wire [63:0] dco_nom_full = `DCO_NOM64;
  wire [31:0] dco_nom_w = dco_nom_full[31:0];
  wire [3:0] rts_err = rx_rts_reg - loc_rts;
  wire [8:0] fill_err = {1'b0, fill_level} - `FILL_MID;
  wire [31:0] adj_rts = {{20{rts_err[3]}}, rts_err, 8'h00};
  wire [31:0] adj_fill = {{16{fill_err[8]}}, fill_err, 7'h00};
  wire [31:0] dco_step = ctrl_reg[`C_ADAPT] ? dco_nom_w + adj_fill : dco_nom_w - adj_rts;
  wire [32:0] dco_sum = {1'b0, dco_acc_reg} + {1'b0, dco_step};

  rts_gen internal_clock_recovery (
    .hclk(hclk),
    .hresetn(hresetn),
    .data_tick(tx_clk_tick),
    .net_tick(net_tick),
    .rts_value(loc_rts)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dco_acc_reg <= 32'h0000_0000;
      tx_clk_tick <= 1'b0;
    end else if (ctrl_reg[`C_EN]) begin
      dco_acc_reg <= dco_sum[31:0];
      tx_clk_tick <= dco_sum[32];
    end else begin
      tx_clk_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Channel associated signalling
  // ----------------------------------------
  reg [4:0] frame_reg;
  wire ds1 = ctrl_reg[`C_DS1];
  wire [4:0] last_frame = ds1 ? `DS1_LAST : `E1_LAST;
  wire [4:0] first_frame = ds1 ? 5'h01 : 5'h00;
  wire [4:0] frame_nx = (frame_reg == last_frame) ? first_frame : frame_reg + 5'h01;
  wire [4:0] ch_lo = frame_nx - 5'h01;
  wire [4:0] ch_hi = frame_nx + 5'h0e;
  wire [1:0] quarter = (frame_reg == 5'h06) ? 2'h0 :
                       (frame_reg == 5'h0c) ? 2'h1 :
                       (frame_reg == 5'h12) ? 2'h2 : 2'h3;
  wire rob_now = ds1 && is_robbed(frame_reg);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_reg <= 5'h00;
      ts16_byte <= 8'h00;
      robbed_frame <= 1'b0;
      robbed_bit <= 1'b0;
      signalling_multiframe_start <= 1'b0;
      sig_sub_valid <= 1'b0;
    end else begin
      signalling_multiframe_start <= 1'b0;
      sig_sub_valid <= 1'b0;
      robbed_bit <= rob_now && (ds1_chan < 5'h1e) &&
                    sig_pick(sig_mem[ds1_chan], quarter, ctrl_reg[`C_GRP]);
      if (frame_tick) begin
        frame_reg <= frame_nx;
        robbed_frame <= ds1 && is_robbed(frame_nx);
        if (frame_nx == first_frame) begin
          signalling_multiframe_start <= 1'b1;
          sig_sub_valid <= ctrl_reg[`C_SIGSUB];
        end
        if (frame_nx == 5'h00) begin
          ts16_byte <= {4'h0, 1'b1, ctrl_reg[`C_ALARM], 2'h3};
        end else if (!ds1 && frame_nx <= `E1_LAST) begin
          ts16_byte <= {sig_mem[ch_lo], sig_mem[ch_hi]};
        end else begin
          ts16_byte <= 8'hff;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/aal1_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module aal1_top_props (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire rx_cell_valid,
  input wire rx_accept,
  input wire rx_discard,
  input wire rx_dummy_octet,
  input wire tx_cell_req,
  input wire tx_cell_valid,
  input wire [2:0] tx_sc,
  input wire ptr_valid,
  input wire [6:0] ptr_value,
  input wire frame_tick,
  input wire [7:0] ts16_byte,
  input wire robbed_frame
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  reg [11:0] dcnt;
  reg [3:0] pcnt;
  reg [2:0] last_sc;
  reg seen;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dcnt <= 12'h000;
      pcnt <= 4'h0;
      last_sc <= 3'h0;
      seen <= 1'b0;
    end else begin
      dcnt <= rx_dummy_octet ? dcnt + 12'h001 : 12'h000;
      if (tx_cell_valid) begin
        seen <= 1'b1;
        last_sc <= tx_sc;
        pcnt <= (tx_sc == 3'h7) ? 4'h0 : pcnt + {3'h0, ptr_valid};
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence tx_taken;
    tx_cell_req ##1 tx_cell_valid;
  endsequence
  sequence decided;
    rx_accept || rx_discard;
  endsequence
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  zero_wait_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  one_verdict_a: assert property (!(rx_accept && rx_discard))
    else $error("accept and discard together");
  decide_on_cell_a: assert property (decided |-> $past(rx_cell_valid))
    else $error("verdict without arriving cell");
  dummy_whole_a: assert property ($fell(rx_dummy_octet) |->
    (dcnt % 12'h02f == 12'h000) && dcnt != 12'h000)
    else $error("dummy burst not whole cells");
  dummy_start_a: assert property ($rose(rx_dummy_octet) |->
    $past(rx_cell_valid, 1) || $past(rx_cell_valid, 2) || $past(rx_cell_valid, 3))
    else $error("dummy burst without cell");
  tx_answer_a: assert property (tx_cell_req |-> tx_taken)
    else $error("no transmit cell after request");
  tx_cause_a: assert property (tx_cell_valid |-> $past(tx_cell_req))
    else $error("transmit cell without request");
  sc_step_a: assert property (tx_cell_valid && seen |-> tx_sc == last_sc + 3'h1)
    else $error("sequence count skipped");
  ptr_once_a: assert property (tx_cell_valid && tx_sc == 3'h7 |->
    pcnt + {3'h0, ptr_valid} == 4'h1)
    else $error("pointer count per cycle not one");
  ptr_range_a: assert property (tx_cell_valid && ptr_valid |->
    ptr_value < 7'h5d || ptr_value == 7'h7f)
    else $error("pointer outside span");
  frame_hold_a: assert property ($changed(ts16_byte) || $changed(robbed_frame) |->
    $past(frame_tick))
    else $error("frame content changed off frame tick");
endmodule
bind aal1_top aal1_top_props aal1_top_props_i (.hclk, .hresetn, .hreadyout, .hresp,
  .rx_cell_valid, .rx_accept, .rx_discard, .rx_dummy_octet, .tx_cell_req, .tx_cell_valid,
  .tx_sc, .ptr_valid, .ptr_value, .frame_tick, .ts16_byte, .robbed_frame);
`default_nettype wire

// [tb/atm_layer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module atm_layer_model (
  input wire hclk,
  output logic rx_cell_valid,
  output logic [2:0] rx_cell_sn,
  output logic rx_cell_csi,
  output logic tx_cell_req,
  output logic blk_start_valid,
  output logic [6:0] blk_start_off
);
  initial begin
    rx_cell_valid = 1'b0;
    rx_cell_sn = 3'h0;
    rx_cell_csi = 1'b0;
    tx_cell_req = 1'b0;
    blk_start_valid = 1'b0;
    blk_start_off = 7'h00;
  end
  // Released lines show the inverse, never a stale value
  task send_cell(input logic [2:0] sn, input int gap);
    @(posedge hclk);
    rx_cell_valid <= 1'b1;
    rx_cell_sn <= sn;
    rx_cell_csi <= sn[0];
    @(posedge hclk);
    rx_cell_valid <= 1'b0;
    rx_cell_sn <= ~sn;
    rx_cell_csi <= ~sn[0];
    repeat (gap) @(posedge hclk);
  endtask
  task send_tx(input logic bv, input logic [6:0] off);
    @(posedge hclk);
    tx_cell_req <= 1'b1;
    blk_start_valid <= bv;
    blk_start_off <= off;
    @(posedge hclk);
    tx_cell_req <= 1'b0;
    blk_start_valid <= ~bv;
    blk_start_off <= ~off;
    repeat (3) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// [tb/aal1_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module aal1_top_tb;
  logic hclk, hresetn, hsel, hwrite, hready, rx_cell_valid, rx_cell_csi, tx_cell_req;
  logic blk_start_valid, data_tick, net_tick, frame_tick, tx_cell_valid, tx_csi, ptr_valid;
  logic rx_accept, rx_discard, rx_dummy_octet, hreadyout, hresp, tx_clk_tick;
  logic robbed_frame, robbed_bit, mf_start, sig_sub_valid, rd_pend, mf_seen;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, rx_cell_sn, tx_sc;
  logic [6:0] blk_start_off, ptr_value, off;
  logic [7:0] fill_level, ts16_byte;
  logic [4:0] ds1_chan;
  logic [63:0] rd_q[$];
  logic [1:0] rx_q[$];
  logic [10:0] tx_q[$];
  int failures, check_count, dummies, k, clk_ticks;
  int seed = 11368;
  logic [2:0] sns[8] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3, 3'h4, 3'h6, 3'h7};
  logic [1:0] ev[8] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2};
  assign hready = hreadyout;
  aal1_top aal1_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .rx_cell_valid, .rx_cell_sn, .rx_cell_csi,
    .rx_accept, .rx_discard, .rx_dummy_octet, .tx_cell_req, .blk_start_valid,
    .blk_start_off, .tx_cell_valid, .tx_sc, .tx_csi, .ptr_valid, .ptr_value, .data_tick,
    .net_tick, .fill_level, .tx_clk_tick, .frame_tick, .ds1_chan, .ts16_byte,
    .robbed_frame, .robbed_bit, .signalling_multiframe_start(mf_start), .sig_sub_valid);
  atm_layer_model atm_layer_model_i (.hclk, .rx_cell_valid, .rx_cell_sn, .rx_cell_csi,
    .tx_cell_req, .blk_start_valid, .blk_start_off);
  always #2 hclk = ~hclk;
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    failures++;
    report_and_stop();
  end
  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge hclk) begin
    logic [63:0] e;
    logic [10:0] t;
    if (rd_pend) begin
      e = rd_q.pop_front();
      check(hrdata & e[63:32], e[31:0], "hrdata");
    end
    rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
    if (rx_accept || rx_discard) check(32'({rx_accept, rx_discard}), 32'(rx_q.pop_front()), "verdict");
    dummies += 32'(rx_dummy_octet);
    clk_ticks += 32'(tx_clk_tick);
    if (tx_cell_valid) begin
      t = tx_q.pop_front();
      check(32'(tx_sc), 32'(t[10:8]), "tx_sc");
      check(32'(ptr_valid), 32'(t[7]), "ptr_valid");
      if (t[7]) check(32'(ptr_value), 32'(t[6:0]), "ptr_value");
      if (!tx_sc[0]) check(32'(tx_csi), 32'(t[7]), "tx_csi");
    end
    if (mf_start) begin
      mf_seen = 1'b1;
      check(32'(ts16_byte), 32'h0000_000f, "frame0 slot16");
      check(32'(sig_sub_valid), 32'h0000_0000, "signalling substructure");
    end
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  always @(posedge hclk) begin
    data_tick <= ($random(seed) & 3) == 0;
    net_tick <= ($random(seed) & 1) == 0;
    fill_level <= 8'($random(seed));
    ds1_chan <= 5'($random(seed) & 15);
  end
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        failures++;
        report_and_stop();
      end
      if (p == 0) begin
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
      end
    end
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] mask);
    rd_q.push_back({mask, exp});
    ahb(1'b0, a, 32'h0000_0000);
  endtask
  task tick;
    @(posedge hclk);
    frame_tick <= 1'b1;
    @(posedge hclk);
    frame_tick <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, frame_tick, rd_pend, mf_seen} = 7'h00;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {data_tick, net_tick, fill_level, ds1_chan} = 15'h0000;
    {failures, check_count, dummies} = {32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(32'h0000_0000, 32'h0000_0000, 32'hffff_ffff);
    rd(32'h0000_0004, 32'h0004_0000, 32'h0007_0000);
    ahb(1'b1, 32'h0000_0040, 32'h0000_000a);
    ahb(1'b1, 32'h0000_0020, 32'hffff_ffff);
    rd(32'h0000_0040, 32'h0000_000a, 32'hffff_ffff);
    rd(32'h0000_0020, 32'h0000_0000, 32'hffff_ffff);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
      ahb(1'b1, 32'h0000_0000, 32'h0000_0011 | 32'(m << 1)); // Robust, then fast
      @(posedge hclk);
      rd(32'h0000_0004, 32'h0000_0000, 32'h0007_0000);
      for (k = 0; k < 8; k++) begin
        if (ev[k] != 2'h0) rx_q.push_back(ev[k]);
        atm_layer_model_i.send_cell(sns[k], 60);
      end
      check(32'(dummies), 32'h0000_002f * (m + 1), "dummy octets");
      rd(32'h0000_0008, 32'h0001_0001 * (m + 1), 32'hffff_ffff);
      rd(32'h0000_0004, 32'h0002_0000, 32'h0007_0000);
    end
    $display("test sequence done");
    for (k = 0; k < 8; k++) begin
      tx_q.push_back({3'(k), k == 7, 7'h7f});
      atm_layer_model_i.send_tx(1'b0, 7'h00);
    end
    off = 7'(($random(seed) & 32'h7fff_ffff) % 93);
    for (k = 0; k < 8; k++) begin
      tx_q.push_back({3'(k), k == 3, off});
      atm_layer_model_i.send_tx(k == 3 || k == 5, off);
    end
    $display("test pointer done");
    for (k = 0; k < 40 && !mf_seen; k++) tick();
    check(32'(mf_seen), 32'h0000_0001, "multiframe start");
    tick();
    check(32'(ts16_byte), 32'h0000_00a0, "frame1 slot16");
    $display("test signalling done");
    ahb(1'b1, 32'h0000_0000, 32'h0000_0015);
    clk_ticks = 0;
    repeat (1000) @(posedge hclk);
    check(32'(clk_ticks >= 8 && clk_ticks <= 9), 32'h0000_0001, "recovered ticks");
    $display("test clock done");
    ahb(1'b1, 32'h0000_0000, 32'h0000_0009);
    for (k = 0; k < 30 && !robbed_frame; k++) tick();
    for (k = 1; k <= 6; k++) begin
      tick();
      check(32'(robbed_frame), 32'(k == 6), "robbed frame");
    end
    $display("test robbed bit done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(32'h0000_0004, 32'h0004_0000, 32'h0007_0000);
    repeat (4) @(posedge hclk);
    check(32'(rx_q.size() + tx_q.size()), 32'h0000_0000, "pending results");
    $display("test reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
